// File: rtl/battery_alert_status_bank.sv
// Read-only alert status bank of the battery acquisition device
`timescale 1ns/1ps
`default_nettype none
`include "alert_bank_consts.svh"
// Contract
// - Summary bit 15 is OR of converter cell overvoltage flags.
// - Summary bit 14 is OR of comparator cell overvoltage flags.
// - Summary bit 13 is OR of converter cell undervoltage flags.
// - Summary bit 12 is OR of comparator cell undervoltage flags.
// - Bits 11..8 OR aux converter/comparator cold and hot flags.
// - Summary bits read-only, clear at acquisition once all sources resolve.
// - Bit 7 set when current is above charge threshold.
// - Bit 6 set when current is below discharge threshold.
// - Bits 4..0 follow latest calibration or calibration write result.
// - Cell overvoltage flag uses polarity threshold, only when enabled.
// - Overvoltage flags clear at next acquisition once resolved.
// - Cell undervoltage flag uses polarity threshold, only when enabled.
// - Field 11:8 holds highest enabled cell from selected data.
// - Field 3:0 holds lowest enabled cell from selected data.
// - Extreme cell fields update only on scan requests.
// - Ties report the lowest cell number.
// - Extreme search uses only the selected polarity set.
// - No matching measurement reports Fh.
// - Aux input over its limit sets protect flag and opens switch.
// - Protect flag clears only on good retry or pin leaving aux role.
// - Aux cold flag set above cold threshold when enabled.
// - Summary register sits read-only at offset 0x7.
module battery_alert_status_bank (
    input  wire logic                     core_clk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     rd_en_i,
    input  wire logic                     wr_en_i,
    input  wire logic [7:0]               addr_i,
    output logic      [15:0]              rd_data_o,
    input  wire logic                     acq_done_i,
    input  wire alert_bank_pkg::cell_cfg_t cell_cfg_i,
    input  wire alert_bank_pkg::cells_t   cell_raw_i,
    input  wire alert_bank_pkg::cells_t   cell_filt_i,
    input  wire logic                     cmp_done_i,
    input  wire alert_bank_pkg::cmp_cond_t cmp_cond_i,
    input  wire logic                     aux_done_i,
    input  wire alert_bank_pkg::aux_t     aux_data_i,
    input  wire alert_bank_pkg::aux_cfg_t aux_cfg_i,
    input  wire logic                     csa_done_i,
    input  wire alert_bank_pkg::word_t    csa_data_i,
    input  wire alert_bank_pkg::word_t    csa_ov_th_i,
    input  wire alert_bank_pkg::word_t    csa_uv_th_i,
    input  wire logic [4:0]               cal_update_i,
    input  wire logic [4:0]               cal_fault_i,
    input  wire logic [3:0]               aux_is_input_i,
    input  wire logic                     aux_cfg_write_i,
    input  wire logic [3:0]               aux_over_limit_i,
    output logic      [3:0]               aux_switch_en_o
);
    // Greater-than, signed when the data is bipolar
    function automatic logic gt(input logic [15:0] a,
                                input logic [15:0] b,
                                input logic        bip);
        gt = bip ? ($signed(a) > $signed(b)) : (a > b);
    endfunction

    // Extreme search; strict compare keeps the lowest index on ties
    function automatic logic [3:0] extreme(
        input alert_bank_pkg::cells_t d,
        input logic [13:0]            en,
        input logic [13:0]            pol,
        input logic                   xpol,
        input logic                   find_max);
        logic        found;
        logic [15:0] best;
        logic [3:0]  idx;
        found = 1'b0;
        best  = `RST_WORD;
        idx   = `NO_CELL;
        for (int i = 0; i < `NUM_CELLS; i++) begin
            if (en[i] && (pol[i] == xpol)) begin
                if (!found || (find_max ? gt(d[i], best, xpol)
                                        : gt(best, d[i], xpol))) begin
                    found = 1'b1;
                    best  = d[i];
                    idx   = 4'(i + 1);
                end
            end
        end
        extreme = idx;
    endfunction

    logic [13:0] cell_over_flag;
    logic [13:0] cell_under_flag;
    logic [13:0] cmp_cell_over_flag;
    logic [13:0] cmp_cell_under_flag;
    logic [3:0]  aux_cold_flag;
    logic [3:0]  aux_hot_flag;
    logic [3:0]  cmp_aux_cold_flag;
    logic [3:0]  cmp_aux_hot_flag;
    logic        charge_current_high_flag;
    logic        discharge_current_high_flag;
    logic [4:0]  cal_fault_flag;
    logic [3:0]  highest_cell_index;
    logic [3:0]  lowest_cell_index;
    logic [3:0]  aux_protect_flag;
    logic [3:0]  lim_s1;
    logic [3:0]  lim_s2;
    logic [3:0]  lim_s3;
    logic [3:0]  over_limit;
    logic [13:0] next_ov;
    logic [13:0] next_uv;
    logic [15:0] alert_summary;
    logic [15:0] next_rd_data;
    alert_bank_pkg::cells_t sel_data;

    // Per-cell threshold checks on the latest converter data
    always_comb begin
        for (int i = 0; i < `NUM_CELLS; i++) begin
            next_ov[i] = cell_cfg_i.cell_over_enable[i] &&
                (cell_cfg_i.polarity[i]
                 ? gt(cell_raw_i[i], cell_cfg_i.bipolar_over_threshold,
                      1'b1)
                 : gt(cell_raw_i[i], cell_cfg_i.unipolar_over_threshold,
                      1'b0));
            next_uv[i] = cell_cfg_i.cell_under_enable[i] &&
                (cell_cfg_i.polarity[i]
                 ? gt(cell_cfg_i.bipolar_under_threshold, cell_raw_i[i],
                      1'b1)
                 : gt(cell_cfg_i.unipolar_under_threshold, cell_raw_i[i],
                      1'b0));
        end
    end

    // Converter cell flags; re-evaluated on every acquisition
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cell_over_flag  <= `RST_CELLS;
            cell_under_flag <= `RST_CELLS;
        end else if (acq_done_i) begin
            cell_over_flag  <= next_ov;
            cell_under_flag <= next_uv;
        end
    end

    a_cell_ov_gate: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        acq_done_i && !cell_cfg_i.cell_over_enable[0]
        |=> !cell_over_flag[0])
        else $error("disabled cell overvoltage flag set");

    // Redundant comparator flags, gated by the same enables
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cmp_cell_over_flag  <= `RST_CELLS;
            cmp_cell_under_flag <= `RST_CELLS;
            cmp_aux_cold_flag   <= `RST_AUX;
            cmp_aux_hot_flag    <= `RST_AUX;
        end else if (cmp_done_i) begin
            cmp_cell_over_flag  <= cmp_cond_i.cell_over &
                                   cell_cfg_i.cell_over_enable;
            cmp_cell_under_flag <= cmp_cond_i.cell_under &
                                   cell_cfg_i.cell_under_enable;
            cmp_aux_cold_flag   <= cmp_cond_i.aux_cold &
                                   aux_cfg_i.aux_cold_enable;
            cmp_aux_hot_flag    <= cmp_cond_i.aux_hot &
                                   aux_cfg_i.aux_hot_enable;
        end
    end

    // Auxiliary cold and hot flags from converter data
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            aux_cold_flag <= `RST_AUX;
            aux_hot_flag  <= `RST_AUX;
        end else if (aux_done_i) begin
            for (int n = 0; n <= `AUX_HI; n++) begin
                aux_cold_flag[n] <= aux_cfg_i.aux_cold_enable[n] &&
                    gt(aux_data_i[n], aux_cfg_i.cold_threshold,
                       1'b0);
                aux_hot_flag[n]  <= aux_cfg_i.aux_hot_enable[n] &&
                    gt(aux_cfg_i.hot_threshold, aux_data_i[n], 1'b0);
            end
        end
    end

    a_aux_cold_gate: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        aux_done_i && !aux_cfg_i.aux_cold_enable[0]
        |=> !aux_cold_flag[0])
        else $error("disabled aux cold flag set");

    // Current-sense alerts, signed since current flows both ways
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            charge_current_high_flag    <= 1'b0;
            discharge_current_high_flag <= 1'b0;
        end else if (csa_done_i) begin
            charge_current_high_flag    <=
                gt(csa_data_i, csa_ov_th_i, 1'b1);
            discharge_current_high_flag <=
                gt(csa_uv_th_i, csa_data_i, 1'b1);
        end
    end

    a_csa_discharge: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        csa_done_i |=> discharge_current_high_flag ==
        ($signed($past(csa_uv_th_i)) > $signed($past(csa_data_i))))
        else $error("discharge current alert mismatch");

    // Calibration faults follow each new result, per bit
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cal_fault_flag <= `RST_CAL;
        end else begin
            for (int k = `CAL_LO; k <= `CAL_HI; k++) begin
                if (cal_update_i[k]) begin
                    cal_fault_flag[k] <= cal_fault_i[k];
                end
            end
        end
    end

    // Extreme search works on the data chosen by the filter select
    assign sel_data = cell_cfg_i.read_filter_select ? cell_filt_i
                                                    : cell_raw_i;

    // Only scan acquisitions refresh the extreme cell fields
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            highest_cell_index <= `RST_IDX;
            lowest_cell_index  <= `RST_IDX;
        end else if (acq_done_i && cell_cfg_i.scan) begin
            highest_cell_index <= extreme(sel_data,
                cell_cfg_i.cell_channel_enable, cell_cfg_i.polarity,
                cell_cfg_i.extreme_polarity_select, 1'b1);
            lowest_cell_index  <= extreme(sel_data,
                cell_cfg_i.cell_channel_enable, cell_cfg_i.polarity,
                cell_cfg_i.extreme_polarity_select, 1'b0);
        end
    end

    // Limit detector is asynchronous; three stages, agree on two
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            lim_s1     <= `RST_AUX;
            lim_s2     <= `RST_AUX;
            lim_s3     <= `RST_AUX;
            over_limit <= `RST_AUX;
        end else begin
            lim_s1 <= aux_over_limit_i;
            lim_s2 <= lim_s1;
            lim_s3 <= lim_s2;
            for (int n = 0; n <= `AUX_HI; n++) begin
                if (lim_s2[n] == lim_s3[n]) begin
                    over_limit[n] <= lim_s3[n];
                end
            end
        end
    end

    // Protection latch; a new fault wins over a retry clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            aux_protect_flag <= `RST_AUX;
        end else begin
            for (int n = 0; n <= `AUX_HI; n++) begin
                if (!aux_is_input_i[n]) begin
                    aux_protect_flag[n] <= 1'b0;
                end else if (over_limit[n]) begin
                    aux_protect_flag[n] <= 1'b1;
                end else if (aux_cfg_write_i) begin
                    aux_protect_flag[n] <= 1'b0;
                end
            end
        end
    end

    // Switch stays open until the flag is cleared by a good retry
    assign aux_switch_en_o = aux_is_input_i & ~aux_protect_flag;

    // Summary bits follow the detail flags, so they clear with them
    always_comb begin
        alert_summary = `RST_WORD;
        alert_summary[`SB_CONV_OV]   = |cell_over_flag;
        alert_summary[`SB_CMP_OV]    = |cmp_cell_over_flag;
        alert_summary[`SB_CONV_UV]   = |cell_under_flag;
        alert_summary[`SB_CMP_UV]    = |cmp_cell_under_flag;
        alert_summary[`SB_CONV_COLD] = |aux_cold_flag;
        alert_summary[`SB_CMP_COLD]  = |cmp_aux_cold_flag;
        alert_summary[`SB_CONV_HOT]  = |aux_hot_flag;
        alert_summary[`SB_CMP_HOT]   = |cmp_aux_hot_flag;
        alert_summary[`SB_CHG_HIGH]  = charge_current_high_flag;
        alert_summary[`SB_DIS_HIGH]  = discharge_current_high_flag;
        alert_summary[`CAL_HI:`CAL_LO] = cal_fault_flag;
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        next_rd_data = `RST_WORD;
        unique case (addr_i)
            `OFS_SUMMARY:  next_rd_data = alert_summary;
            `OFS_CELL_OV:  next_rd_data[13:0] = cell_over_flag;
            `OFS_CELL_UV:  next_rd_data[13:0] = cell_under_flag;
            `OFS_EXTREME: begin
                next_rd_data[`HI_IDX_HI:`HI_IDX_LO] = highest_cell_index;
                next_rd_data[`LO_IDX_HI:`LO_IDX_LO] = lowest_cell_index;
            end
            `OFS_AUX_PROT: next_rd_data[`AUX_HI:0] = aux_protect_flag;
            `OFS_AUX_COLD: next_rd_data[`AUX_HI:0] = aux_cold_flag;
            `OFS_AUX_HOT:  next_rd_data[`AUX_HI:0] = aux_hot_flag;
            default:       next_rd_data = `RST_WORD;
        endcase
    end

    // Read data registered; write strobe has no path into the bank
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= `RST_WORD;
        end else if (rd_en_i) begin
            rd_data_o <= next_rd_data;
        end
    end

    a_sum_conv_ov: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        alert_summary[`SB_CONV_OV] == (|cell_over_flag))
        else $error("converter overvoltage summary mismatch");
    a_sum_cmp_ov: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        cmp_done_i |=> alert_summary[`SB_CMP_OV] ==
        |$past(cmp_cond_i.cell_over & cell_cfg_i.cell_over_enable))
        else $error("comparator overvoltage summary mismatch");
    a_sum_conv_uv: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        acq_done_i |=> alert_summary[`SB_CONV_UV] == |$past(next_uv))
        else $error("converter undervoltage summary mismatch");
    a_sum_hold: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        !acq_done_i ##1 !$past(sys_rst_i)
        |-> $stable(alert_summary[`SB_CONV_OV]))
        else $error("summary changed without acquisition");
    a_csa_charge: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        csa_done_i && ($signed(csa_data_i) > $signed(csa_ov_th_i))
        |=> charge_current_high_flag)
        else $error("charge current alert not set");
    a_cal_follow: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        cal_update_i[0] |=> cal_fault_flag[0] == $past(cal_fault_i[0]))
        else $error("calibration fault not updated");
    a_extreme_noscan: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        !(acq_done_i && cell_cfg_i.scan)
        |=> $stable(highest_cell_index) && $stable(lowest_cell_index))
        else $error("extreme cell field changed without scan");
    a_extreme_none: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        acq_done_i && cell_cfg_i.scan &&
        ((cell_cfg_i.cell_channel_enable &
          ~(cell_cfg_i.polarity ^ {14{cell_cfg_i.extreme_polarity_select}}))
         == `RST_CELLS)
        |=> highest_cell_index == `NO_CELL)
        else $error("missing no-result code");
    a_protect_switch: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        aux_is_input_i[0] && over_limit[0]
        |=> aux_protect_flag[0] || !aux_is_input_i[0])
        else $error("protection flag not set on limit");
    a_protect_keep: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        aux_protect_flag[0] && aux_is_input_i[0] && !aux_cfg_write_i
        |=> aux_protect_flag[0])
        else $error("protection flag cleared without retry");
    a_write_ignored: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        wr_en_i && !rd_en_i |=> $stable(rd_data_o))
        else $error("write disturbed read data");
endmodule
`default_nettype wire

// File: rtl/alert_bank_consts.svh
// Offsets, field positions and reset values of the alert status bank
`ifndef ALERT_BANK_CONSTS_SVH
`define ALERT_BANK_CONSTS_SVH
`define OFS_SUMMARY    8'h07
`define OFS_CELL_OV    8'h08
`define OFS_CELL_UV    8'h09
`define OFS_EXTREME    8'h0a
`define OFS_AUX_PROT   8'h0b
`define OFS_AUX_COLD   8'h0c
`define OFS_AUX_HOT    8'h0d
`define RST_WORD       16'h0000
`define RST_CELLS      14'h0000
`define RST_AUX        4'h0
`define RST_CAL        5'h00
`define RST_IDX        4'h0
`define NO_CELL        4'hf
`define SB_CONV_OV     15
`define SB_CMP_OV      14
`define SB_CONV_UV     13
`define SB_CMP_UV      12
`define SB_CONV_COLD   11
`define SB_CMP_COLD    10
`define SB_CONV_HOT    9
`define SB_CMP_HOT     8
`define SB_CHG_HIGH    7
`define SB_DIS_HIGH    6
`define CAL_HI         4
`define CAL_LO         0
`define HI_IDX_HI      11
`define HI_IDX_LO      8
`define LO_IDX_HI      3
`define LO_IDX_LO      0
`define AUX_HI         3
`define NUM_CELLS      14
`endif

// File: rtl/alert_bank_pkg.sv
// Types shared by the alert status bank
package alert_bank_pkg;
    typedef logic [15:0] word_t;
    typedef logic [13:0][15:0] cells_t;
    typedef logic [3:0][15:0] aux_t;
    // Cell acquisition configuration
    typedef struct packed {
        logic        scan;
        logic        read_filter_select;
        logic        extreme_polarity_select;
        logic [13:0] polarity;
        logic [13:0] cell_channel_enable;
        logic [13:0] cell_over_enable;
        logic [13:0] cell_under_enable;
        word_t       unipolar_over_threshold;
        word_t       bipolar_over_threshold;
        word_t       unipolar_under_threshold;
        word_t       bipolar_under_threshold;
    } cell_cfg_t;
    // Auxiliary alert configuration
    typedef struct packed {
        logic [3:0] aux_cold_enable;
        logic [3:0] aux_hot_enable;
        word_t      cold_threshold;
        word_t      hot_threshold;
    } aux_cfg_t;
    // Redundant comparator conditions
    typedef struct packed {
        logic [13:0] cell_over;
        logic [13:0] cell_under;
        logic [3:0]  aux_cold;
        logic [3:0]  aux_hot;
    } cmp_cond_t;
endpackage

// File: dv/battery_alert_status_bank_tb.sv
// Self-checking testbench of the read-only alert status bank
`timescale 1ns/1ps
`default_nettype none
module battery_alert_status_bank_tb;
    logic                       core_clk_i;
    logic                       sys_rst_i;
    logic                       rd_en_i;
    logic                       wr_en_i;
    logic [7:0]                 addr_i;
    logic [15:0]                rd_data_o;
    logic                       acq_done_i;
    alert_bank_pkg::cell_cfg_t  cc;
    alert_bank_pkg::cells_t     raw;
    alert_bank_pkg::cells_t     filt;
    logic                       cmp_done_i;
    alert_bank_pkg::cmp_cond_t  cmp;
    logic                       aux_done_i;
    alert_bank_pkg::aux_t       aux_d;
    alert_bank_pkg::aux_cfg_t   ac;
    logic                       csa_done_i;
    alert_bank_pkg::word_t      csa_d;
    alert_bank_pkg::word_t      csa_hi;
    alert_bank_pkg::word_t      csa_lo;
    logic [4:0]                 cal_update_i;
    logic [4:0]                 cal_fault_i;
    logic [3:0]                 aux_is_input_i;
    logic                       aux_cfg_write_i;
    logic [3:0]                 aux_over_limit_i;
    logic [3:0]                 aux_switch_en_o;
    int                         error_cnt;
    int                         n_checks;
    int                         cycles;
    logic [7:0]                 bad_addr [4];

    battery_alert_status_bank dut (
        .core_clk_i       (core_clk_i),
        .sys_rst_i        (sys_rst_i),
        .rd_en_i          (rd_en_i),
        .wr_en_i          (wr_en_i),
        .addr_i           (addr_i),
        .rd_data_o        (rd_data_o),
        .acq_done_i       (acq_done_i),
        .cell_cfg_i       (cc),
        .cell_raw_i       (raw),
        .cell_filt_i      (filt),
        .cmp_done_i       (cmp_done_i),
        .cmp_cond_i       (cmp),
        .aux_done_i       (aux_done_i),
        .aux_data_i       (aux_d),
        .aux_cfg_i        (ac),
        .csa_done_i       (csa_done_i),
        .csa_data_i       (csa_d),
        .csa_ov_th_i      (csa_hi),
        .csa_uv_th_i      (csa_lo),
        .cal_update_i     (cal_update_i),
        .cal_fault_i      (cal_fault_i),
        .aux_is_input_i   (aux_is_input_i),
        .aux_cfg_write_i  (aux_cfg_write_i),
        .aux_over_limit_i (aux_over_limit_i),
        .aux_switch_en_o  (aux_switch_en_o)
    );

    // 100 MHz clock
    always #5 core_clk_i = ~core_clk_i;

    // Hang guard, well above the length of the sequence
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One read strobe; data is registered at the strobe's edge
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp,
                         input string nm);
        rd_en_i = 1'b1;
        addr_i  = a;
        @(posedge core_clk_i);
        #1;
        rd_en_i = 1'b0;
        chk(nm, rd_data_o, exp);
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a);
        wr_en_i = 1'b1;
        addr_i  = a;
        @(posedge core_clk_i);
        #1;
        wr_en_i = 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask

    // One-cycle event pulse: 0 cell, 1 comparator, 2 aux, 3 current, 4 retry
    task automatic fire(input int k);
        case (k)
            0: acq_done_i = 1'b1;
            1: cmp_done_i = 1'b1;
            2: aux_done_i = 1'b1;
            3: csa_done_i = 1'b1;
            default: aux_cfg_write_i = 1'b1;
        endcase
        @(posedge core_clk_i);
        #1;
        {acq_done_i, cmp_done_i, aux_done_i} = 3'h0;
        {csa_done_i, aux_cfg_write_i} = 2'h0;
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic cal(input logic [4:0] u, input logic [4:0] f);
        cal_update_i = u;
        cal_fault_i  = f;
        @(posedge core_clk_i);
        #1;
        cal_update_i = 5'h00;
        @(posedge core_clk_i);
        #1;
    endtask

    initial begin
        core_clk_i = 1'b0;
        sys_rst_i = 1'b1;
        {rd_en_i, wr_en_i, acq_done_i, cmp_done_i} = 4'h0;
        {aux_done_i, csa_done_i, aux_cfg_write_i} = 3'h0;
        addr_i = 8'h00;
        cc = '0;
        raw = '0;
        filt = '0;
        cmp = '0;
        aux_d = '0;
        ac = '0;
        csa_d = 16'h0000;
        csa_hi = 16'h0064;
        csa_lo = 16'hff9c;
        cal_update_i = 5'h00;
        cal_fault_i = 5'h00;
        aux_is_input_i = 4'hf;
        aux_over_limit_i = 4'h0;
        error_cnt = 0;
        n_checks = 0;
        cycles = 0;
        bad_addr = '{8'h00, 8'h06, 8'h0e, 8'hff};
        repeat (10) @(posedge core_clk_i);
        #1;
        sys_rst_i = 1'b0;
        // Reset values of every mapped word, then unmapped places
        for (int a = 7; a <= 13; a++) rdchk(8'(a), 16'h0000, "reset");
        foreach (bad_addr[i]) rdchk(bad_addr[i], 16'h0000, "unmapped");
        // Cell flags: unipolar unsigned, bipolar signed thresholds
        cc.unipolar_over_threshold  = 16'h1000;
        cc.unipolar_under_threshold = 16'h0200;
        cc.bipolar_over_threshold   = 16'h0800;
        cc.bipolar_under_threshold  = 16'hff00;
        cc.cell_channel_enable = 14'h3fff;
        cc.cell_over_enable  = 14'h2fff;
        cc.cell_under_enable = 14'h3fff;
        cc.polarity = 14'h0500;
        for (int i = 0; i < 14; i++) raw[i] = 16'h0800;
        raw[2] = 16'h1200;
        raw[5] = 16'h0100;
        raw[8] = 16'h0900;
        raw[10] = 16'hfe00;
        raw[12] = 16'h1200;
        filt = raw;
        fire(0);
        rdchk(8'h08, 16'h0104, "cell over");
        rdchk(8'h09, 16'h0420, "cell under");
        rdchk(8'h07, 16'ha000, "summary cells");
        // Writes to the cell overvoltage and summary words leave the flags alone
        wr(8'h08);
        wr(8'h07);
        rdchk(8'h08, 16'h0104, "after write");
        rdchk(8'h07, 16'ha000, "summary after write");
        // Conditions resolved at the next acquisition
        for (int i = 0; i < 14; i++) raw[i] = 16'h0800;
        cc.polarity = 14'h0000;
        filt = raw;
        fire(0);
        rdchk(8'h08, 16'h0000, "over cleared");
        rdchk(8'h09, 16'h0000, "under cleared");
        rdchk(8'h07, 16'h0000, "summary cleared");
        // Comparator conditions feed summary bits only
        ac.aux_cold_enable = 4'hf;
        ac.aux_hot_enable = 4'hf;
        cmp.cell_over = 14'h0001;
        cmp.aux_cold = 4'h2;
        fire(1);
        rdchk(8'h07, 16'h4400, "cmp over");
        cmp = '0;
        cmp.cell_under = 14'h0001;
        cmp.aux_hot = 4'h2;
        fire(1);
        rdchk(8'h07, 16'h1100, "cmp under");
        cmp = '0;
        fire(1);
        rdchk(8'h07, 16'h0000, "cmp cleared");
        // Auxiliary cold and hot flags
        ac.cold_threshold = 16'h0800;
        ac.hot_threshold = 16'h0200;
        aux_d = {16'h0100, 16'h0400, 16'h0400, 16'h0900};
        fire(2);
        rdchk(8'h0c, 16'h0001, "aux cold");
        rdchk(8'h0d, 16'h0008, "aux hot");
        rdchk(8'h07, 16'h0a00, "summary aux");
        ac.aux_cold_enable = 4'he;
        fire(2);
        rdchk(8'h0c, 16'h0000, "cold disabled");
        // Current alerts, signed compare
        csa_d = 16'h00c8;
        fire(3);
        rdchk(8'h07, 16'h0280, "charge high");
        csa_d = 16'hff38;
        fire(3);
        rdchk(8'h07, 16'h0240, "discharge high");
        csa_d = 16'h0000;
        fire(3);
        aux_d = {4{16'h0400}};
        fire(2);
        rdchk(8'h07, 16'h0000, "current cleared");
        // Calibration alerts set in one update, then cleared per update mask
        cal(5'h1f, 5'h15);
        rdchk(8'h07, 16'h0015, "cal set");
        cal(5'h01, 5'h00);
        rdchk(8'h07, 16'h0014, "cal cleared");
        cal(5'h14, 5'h00);
        // Extreme search on filtered data, ties and disabled cell
        for (int i = 0; i < 14; i++) filt[i] = 16'h0100 + 16'(i);
        filt[4] = 16'h0200;
        filt[9] = 16'h0200;
        filt[6] = 16'h0010;
        filt[11] = 16'h0010;
        for (int i = 0; i < 14; i++) raw[i] = 16'h0500;
        raw[2] = 16'h0900;
        cc.cell_over_enable = 14'h0000;
        cc.cell_under_enable = 14'h0000;
        cc.cell_channel_enable = 14'h3fef;
        cc.scan = 1'b1;
        cc.read_filter_select = 1'b1;
        fire(0);
        rdchk(8'h0a, 16'h0a07, "extreme filt");
        cc.scan = 1'b0;
        cc.read_filter_select = 1'b0;
        fire(0);
        rdchk(8'h0a, 16'h0a07, "no scan hold");
        cc.scan = 1'b1;
        fire(0);
        rdchk(8'h0a, 16'h0301, "extreme raw");
        cc.extreme_polarity_select = 1'b1;
        fire(0);
        rdchk(8'h0a, 16'h0f0f, "no bipolar");
        cc.polarity = 14'h0030;
        fire(0);
        rdchk(8'h0a, 16'h0606, "bipolar set");
        // Protection: set, retry refused while over, good retry clears
        aux_over_limit_i = 4'h2;
        repeat (8) @(posedge core_clk_i);
        #1;
        rdchk(8'h0b, 16'h0002, "protect set");
        chk("switch", {12'h000, aux_switch_en_o}, 16'h000d);
        fire(4);
        rdchk(8'h0b, 16'h0002, "bad retry");
        aux_over_limit_i = 4'h0;
        repeat (8) @(posedge core_clk_i);
        #1;
        rdchk(8'h0b, 16'h0002, "no retry hold");
        fire(4);
        rdchk(8'h0b, 16'h0000, "good retry");
        aux_over_limit_i = 4'h8;
        repeat (8) @(posedge core_clk_i);
        #1;
        rdchk(8'h0b, 16'h0008, "protect again");
        aux_is_input_i = 4'h7;
        @(posedge core_clk_i);
        #1;
        rdchk(8'h0b, 16'h0000, "pin released");
        chk("switch off", {12'h000, aux_switch_en_o}, 16'h0007);
        print_verdict();
    end
endmodule
`default_nettype wire
